// File: hdl/usbdx_pkg.sv
// Package: register map, field layout and endpoint constants of the USB transceiver control
package usbdx_pkg;
    localparam int unsigned ADDR_W = 8;                        // AXI address width
    localparam logic [ADDR_W-1:0] XCN_OFFS = 8'h00;            // Transceiver control
    localparam logic [ADDR_W-1:0] STAT_OFFS = 8'h04;           // VBUS status; line levels read back in control
    localparam logic [7:0] XCN_RESET = 8'h00;                  // All off after reset
    localparam logic [7:0] XCN_WMASK = 8'hF8;                  // Bits 2..0 read only
    localparam int unsigned PREN_BIT = 7;                      // Pull-up enable
    localparam int unsigned PHYEN_BIT = 6;                     // Transceiver enable
    localparam int unsigned SPEED_BIT = 5;                     // 1 full, 0 low speed
    localparam int unsigned TST_HI = 4;                        // Test mode field
    localparam int unsigned TST_LO = 3;
    localparam int unsigned DFREC_BIT = 2;                     // Differential receiver
    localparam int unsigned DP_BIT = 1;                        // D+ level
    localparam int unsigned DN_BIT = 0;                        // D- level
    localparam int unsigned VBUS_BIT = 0;                      // Status: VBUS present
    localparam logic [1:0] TST_NORMAL = 2'h0;                  // Normal operation
    localparam logic [1:0] TST_J = 2'h1;                       // Drive D+ high, D- low
    localparam logic [1:0] TST_K = 2'h2;                       // Drive D+ low, D- high
    localparam logic [1:0] TST_SE0 = 2'h3;                     // Drive both low
    localparam logic [1:0] RESP_OKAY = 2'h0;                   // AXI OKAY
    localparam logic [1:0] RESP_SLVERR = 2'h2;                 // AXI SLVERR, unmapped
    localparam int unsigned NUM_PIPES = 8;                     // Pipe count
    localparam logic [3:0] EP_MAX = 4'h3;                      // Highest endpoint number
    localparam logic [7:0] ADDR_IN_FLAG = 8'h80;               // IN direction flag
    typedef enum logic [1:0] {
        USBDX_WS_IDLE = 2'b01,
        USBDX_WS_RESP = 2'b10
    } usbdx_wstate_t;
endpackage

// File: hdl/usbdx_ep_decode.sv
// Endpoint token decoder: pipe index and protocol address for a token
`timescale 1ns/100ps
module usbdx_ep_decode (
    input wire logic [3:0] ep_i,
    input wire logic dir_in_i,
    output logic hit_o,
    output logic [2:0] pipe_o,
    output logic [7:0] addr_o
);
    import usbdx_pkg::*;

    // Only endpoints 0..3 exist; both directions exist on each
    always_comb begin
        hit_o = (ep_i <= EP_MAX);
        pipe_o = {ep_i[1:0], dir_in_i};
        // Endpoint zero answers at 0x00 either way
        if (ep_i == 4'h0) begin
            addr_o = 8'h00;
        end else if (dir_in_i) begin
            addr_o = ADDR_IN_FLAG | {4'h0, ep_i};
        end else begin
            addr_o = {4'h0, ep_i};
        end
    end
endmodule

// File: hdl/usbdx_core.sv
// Top: AXI4-Lite transceiver control register, pull-up steering, test drive, token decode
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module usbdx_core (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [usbdx_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [usbdx_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic vbus_i,
    input wire logic dp_i,
    input wire logic dn_i,
    output logic dp_o,
    output logic dp_oe_o,
    output logic dn_o,
    output logic dn_oe_o,
    output logic pullup_dp_o,
    output logic pullup_dn_o,
    output logic xcvr_en_o,
    output logic full_speed_o,
    input wire logic token_valid_i,
    input wire logic [3:0] token_ep_i,
    input wire logic token_dir_in_i,
    output logic ep_hit_o,
    output logic [2:0] ep_pipe_o,
    output logic [7:0] ep_addr_o
);
    import usbdx_pkg::*;

    // Offset match, shared by the write and read paths
    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
        reg_sel = {a == STAT_OFFS, a == XCN_OFFS};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pin_s1_q;                                      // First stage only
    logic [2:0] pin_s2_q;                                      // VBUS, D+, D- safe
    logic vbus_q;
    logic dp_q;
    logic dn_q;

    // Two flops before any logic sees a pin
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else begin
            pin_s1_q <= {vbus_i, dp_i, dn_i};
            pin_s2_q <= pin_s1_q;
        end
    end
    assign vbus_q = pin_s2_q[2];
    assign dp_q = pin_s2_q[1];
    assign dn_q = pin_s2_q[0];

    ////////////////////////////////////////////////////////////////////////////////
    // AXI write channel
    usbdx_wstate_t ws_q;
    logic aw_got_q;                                            // Address held
    logic w_got_q;                                             // Data held
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic [7:0] xcn_q;                                         // Control register
    logic wr_do;                                               // Commit this cycle
    logic [1:0] wr_sel;                                        // Decoded write target

    assign s_axi_awready = (ws_q == USBDX_WS_IDLE) && !aw_got_q;
    assign s_axi_wready = (ws_q == USBDX_WS_IDLE) && !w_got_q;
    assign wr_do = (ws_q == USBDX_WS_IDLE) && aw_got_q && w_got_q;
    // Named net: a bit-select straight on a function call is not legal
    assign wr_sel = reg_sel(awaddr_q);

    // Address and data may come in either order
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ws_q <= USBDX_WS_IDLE;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            case (ws_q)
                USBDX_WS_IDLE: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_got_q <= 1'b1;
                        awaddr_q <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_got_q <= 1'b1;
                        wdata_q <= s_axi_wdata[7:0];
                        wstrb0_q <= s_axi_wstrb[0];
                    end
                    // Both halves in: answer next cycle
                    if (wr_do) begin
                        aw_got_q <= 1'b0;
                        w_got_q <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (reg_sel(awaddr_q) != 2'b00) ? RESP_OKAY : RESP_SLVERR;
                        ws_q <= USBDX_WS_RESP;
                    end
                end
                USBDX_WS_RESP: begin
                    // Hold response until the master takes it
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        ws_q <= USBDX_WS_IDLE;
                    end
                end
                default: begin
                    ws_q <= USBDX_WS_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // Control register; status is read only, so writes there are dropped
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            xcn_q <= XCN_RESET;
        end else if (wr_do && wr_sel[0] && wstrb0_q) begin
            xcn_q <= wdata_q & XCN_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI read channel
    logic [7:0] xcn_rd;                                        // Live view with line bits

    assign xcn_rd = {xcn_q[PREN_BIT:TST_LO], dp_q & ~dn_q, dp_q, dn_q};
    assign s_axi_arready = !s_axi_rvalid;

    // One read in flight; answer one cycle after the address is taken
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (reg_sel(s_axi_araddr))
                2'b01: begin
                    s_axi_rdata <= {24'h00_0000, xcn_rd};
                    s_axi_rresp <= RESP_OKAY;
                end
                2'b10: begin
                    s_axi_rdata <= {31'h0000_0000, vbus_q};
                    s_axi_rresp <= RESP_OKAY;
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transceiver pins
    logic [1:0] tst;
    assign tst = xcn_q[TST_HI:TST_LO];

    // Registered so the pins never glitch on a register write
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pullup_dp_o <= 1'b0;
            pullup_dn_o <= 1'b0;
            xcvr_en_o <= 1'b0;
            full_speed_o <= 1'b0;
            dp_o <= 1'b0;
            dn_o <= 1'b0;
            dp_oe_o <= 1'b0;
            dn_oe_o <= 1'b0;
        end else begin
            // Pull-up follows speed, gated by VBUS
            pullup_dp_o <= xcn_q[PREN_BIT] & xcn_q[SPEED_BIT] & vbus_q;
            pullup_dn_o <= xcn_q[PREN_BIT] & ~xcn_q[SPEED_BIT] & vbus_q;
            xcvr_en_o <= xcn_q[PHYEN_BIT];
            full_speed_o <= xcn_q[SPEED_BIT];
            // Test drive only with the transceiver on; normal data belongs to the engine
            dp_oe_o <= xcn_q[PHYEN_BIT] && (tst != TST_NORMAL);
            dn_oe_o <= xcn_q[PHYEN_BIT] && (tst != TST_NORMAL);
            dp_o <= (tst == TST_J);
            dn_o <= (tst == TST_K);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Token decode: device side only, the block never issues tokens
    logic dec_hit;
    logic [2:0] dec_pipe;
    logic [7:0] dec_addr;

    usbdx_ep_decode u_dec (
        .ep_i(token_ep_i),
        .dir_in_i(token_dir_in_i),
        .hit_o(dec_hit),
        .pipe_o(dec_pipe),
        .addr_o(dec_addr)
    );

    // Answer only tokens that name a pipe we own
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ep_hit_o <= 1'b0;
            ep_pipe_o <= 3'h0;
            ep_addr_o <= 8'h00;
        end else begin
            ep_hit_o <= token_valid_i && dec_hit && xcn_q[PHYEN_BIT];
            ep_pipe_o <= dec_pipe;
            ep_addr_o <= dec_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_pullup_vbus;
        @(posedge clk_i) disable iff (!rstn_i)
        !vbus_q |=> !pullup_dp_o && !pullup_dn_o;
    endproperty
    a_pullup_vbus: assert property (p_pullup_vbus) else $error("pull-up without VBUS");

    property p_full_dp;
        @(posedge clk_i) disable iff (!rstn_i)
        xcn_q[PREN_BIT] && xcn_q[SPEED_BIT] && vbus_q |=> pullup_dp_o && !pullup_dn_o;
    endproperty
    a_full_dp: assert property (p_full_dp) else $error("full speed pull-up wrong");

    property p_low_dn;
        @(posedge clk_i) disable iff (!rstn_i)
        xcn_q[PREN_BIT] && !xcn_q[SPEED_BIT] && vbus_q |=> pullup_dn_o && !pullup_dp_o;
    endproperty
    a_low_dn: assert property (p_low_dn) else $error("low speed pull-up wrong");

    property p_ctrl_write;
        @(posedge clk_i) disable iff (!rstn_i)
        wr_do && awaddr_q == XCN_OFFS && wstrb0_q |=> ##1
            xcvr_en_o == $past(wdata_q[PHYEN_BIT], 2) && full_speed_o == $past(wdata_q[SPEED_BIT], 2);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_test_drive;
        @(posedge clk_i) disable iff (!rstn_i)
        xcn_q[PHYEN_BIT] && tst == TST_SE0 |=> dp_oe_o && dn_oe_o && !dp_o && !dn_o;
    endproperty
    a_test_drive: assert property (p_test_drive) else $error("test drive wrong");

    property p_no_hit;
        @(posedge clk_i) disable iff (!rstn_i)
        token_ep_i > EP_MAX |=> !ep_hit_o;
    endproperty
    a_no_hit: assert property (p_no_hit) else $error("answered unknown endpoint");

    property p_ep0_addr;
        @(posedge clk_i) disable iff (!rstn_i)
        ep_hit_o && ep_pipe_o[2:1] == 2'h0 |-> ep_addr_o == 8'h00;
    endproperty
    a_ep0_addr: assert property (p_ep0_addr) else $error("endpoint zero address wrong");

    property p_in_addr;
        @(posedge clk_i) disable iff (!rstn_i)
        ep_hit_o && ep_pipe_o[2:1] != 2'h0 |->
            ep_addr_o == ({ep_pipe_o[0], 7'h00} | {6'h00, ep_pipe_o[2:1]});
    endproperty
    a_in_addr: assert property (p_in_addr) else $error("endpoint address wrong");

    property p_bvalid_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

    c_full_attach: cover property (@(posedge clk_i) disable iff (!rstn_i) pullup_dp_o);
    c_low_attach: cover property (@(posedge clk_i) disable iff (!rstn_i) pullup_dn_o);
    c_in_token: cover property (@(posedge clk_i) disable iff (!rstn_i) ep_hit_o && ep_addr_o[7]);
    c_unmapped: cover property (@(posedge clk_i) disable iff (!rstn_i)
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

// File: verif/usbdx_host_model.sv
// Host-side partner: issues tokens and sets the bus line levels
`timescale 1ns/100ps
module usbdx_host_model (
    input wire logic clk_i,
    output logic token_valid_o,
    output logic [3:0] token_ep_o,
    output logic token_dir_in_o,
    output logic vbus_o,
    output logic dp_o,
    output logic dn_o
);
    // Quiet bus with no supply until the bench says otherwise
    initial begin
        token_valid_o = 1'b0;
        token_ep_o = 4'h0;
        token_dir_in_o = 1'b0;
        vbus_o = 1'b0;
        dp_o = 1'b0;
        dn_o = 1'b0;
    end
    // Only the host issues tokens; the device merely answers
    task automatic send_token(input logic [3:0] ep, input logic dir);
        token_valid_o <= 1'b1;
        token_ep_o <= ep;
        token_dir_in_o <= dir;
        @(posedge clk_i);
    endtask
    // Released token fields flip so stale values cannot pass for fresh ones
    task automatic idle();
        token_valid_o <= 1'b0;
        token_ep_o <= ~token_ep_o;
        token_dir_in_o <= ~token_dir_in_o;
        @(posedge clk_i);
    endtask
    // Supply and line levels, changed on the edge by non-blocking assignment
    task automatic set_lines(input logic v, input logic p, input logic n);
        vbus_o <= v;
        dp_o <= p;
        dn_o <= n;
        @(posedge clk_i);
    endtask
endmodule

// File: verif/test_usbdx_core.sv
// Self-checking bench: register bus, pull-up steering, test drive, token decode
`timescale 1ns/100ps
module test_usbdx_core;
    import usbdx_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic vbus, dp_in, dn_in, tv, tdir, hit;
    logic [3:0] tep;
    logic [7:0] pins, ep_addr;
    logic [2:0] ep_pipe;
    logic [31:0] q_b[$], q_r[$], q_t[$];
    int fail_count = 0, check_count = 0, cycles = 0;
    logic [31:0] seed = 32'h210e_2cfb;
    //////////////////////////////////////////////////////////////////////////////
    // 10 MHz clock
    always #50 clk_i = ~clk_i;
    usbdx_host_model host_u (.clk_i(clk_i), .token_valid_o(tv), .token_ep_o(tep),
        .token_dir_in_o(tdir), .vbus_o(vbus), .dp_o(dp_in), .dn_o(dn_in));
    usbdx_core dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .vbus_i(vbus), .dp_i(dp_in), .dn_i(dn_in),
        .dp_o(pins[1]), .dp_oe_o(pins[3]), .dn_o(pins[0]), .dn_oe_o(pins[2]),
        .pullup_dp_o(pins[5]), .pullup_dn_o(pins[4]), .xcvr_en_o(pins[7]),
        .full_speed_o(pins[6]), .token_valid_i(tv), .token_ep_i(tep),
        .token_dir_in_i(tdir), .ep_hit_o(hit), .ep_pipe_o(ep_pipe), .ep_addr_o(ep_addr));
    //////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Empty queue yields unknown, so an unasked-for result always mismatches
    function automatic logic [31:0] pop(ref logic [31:0] q[$]);
        return (q.size() > 0) ? q.pop_front() : 32'hxxxx_xxxx;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        cmp(got, exp);
    endtask
    task automatic chk_tok(input logic [10:0] got, input logic [31:0] exp);
        cmp({21'h0, got}, exp);
    endtask
    task automatic chk_pin(input logic [7:0] exp);
        @(negedge clk_i);
        cmp({24'h0, pins}, {24'h0, exp});
        @(posedge clk_i);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////////////
    // Both halves offered together; each dropped once taken, then wait response
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        bit ad = 0, wd = 0, done = 0;
        q_b.push_back({30'h0, r});
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge clk_i);
            if (awvalid && awready) ad = 1;
            if (wvalid && wready) wd = 1;
            @(posedge clk_i);
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        while (!done) begin
            @(negedge clk_i);
            done = bvalid;
            @(posedge clk_i);
        end
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bit done = 0;
        q_r.push_back({r, d[29:0]});
        araddr <= a;
        arvalid <= 1'b1;
        while (!done) begin
            @(negedge clk_i);
            if (arvalid && arready) done = 1;
            @(posedge clk_i);
        end
        arvalid <= 1'b0;
        araddr <= ~a;
        // Raised only now, so back-to-back reads never drive it twice in one step
        rready <= 1'b1;
        done = 0;
        while (!done) begin
            @(negedge clk_i);
            done = rvalid;
            @(posedge clk_i);
        end
        rready <= 1'b0;
    endtask
    // Every result that appears takes the oldest expectation of its kind
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
        if (bvalid && bready) chk_bus({30'h0, bresp}, pop(q_b));
        if (rvalid && rready) chk_bus({rresp, rdata[29:0]}, pop(q_r));
        if (hit) chk_tok({ep_pipe, ep_addr}, pop(q_t));
    end
    //////////////////////////////////////////////////////////////////////////////
    // All 32 endpoint/direction codes in a shuffled back-to-back burst
    task automatic tokens(input bit on);
        logic [4:0] m, c;
        m = seed[4:0];
        seed = xs(seed);
        for (int i = 0; i < 32; i++) begin
            c = i[4:0] ^ m;
            if (on && c[3:0] <= EP_MAX)
                q_t.push_back({21'h0, c[1:0], c[4], (c[3:0] == 0) ? 8'h00 : {c[4], 3'h0, c[3:0]}});
            host_u.send_token(c[3:0], c[4]);
        end
        host_u.idle();
        repeat (2) @(posedge clk_i);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        chk_pin(8'h00);
        axi_rd(XCN_OFFS, 32'h0, RESP_OKAY);
        axi_rd(8'h08, 32'h0, RESP_SLVERR);
        axi_wr(8'h0C, 8'hE0, RESP_SLVERR);
        tokens(1'b0);
        // Clock already runs before the enable goes
        axi_wr(XCN_OFFS, 8'hE0, RESP_OKAY);
        repeat (2) @(posedge clk_i);
        chk_pin(8'hC0);
        host_u.set_lines(1'b1, 1'b0, 1'b0);
        repeat (4) @(posedge clk_i);
        chk_pin(8'hE0);
        axi_rd(STAT_OFFS, 32'h1, RESP_OKAY);
        axi_wr(XCN_OFFS, 8'hC0, RESP_OKAY);
        repeat (2) @(posedge clk_i);
        chk_pin(8'h90);
        tokens(1'b1);
        for (int k = 0; k < 4; k++) begin
            host_u.set_lines(1'b1, seed[0], seed[1]);
            // Random low bits land on read-only fields and must be dropped
            axi_wr(XCN_OFFS, {3'b010, k[1:0], seed[7:5]}, RESP_OKAY);
            repeat (4) @(posedge clk_i);
            chk_pin({4'h8, k != 0, k != 0, k == 1, k == 2});
            axi_rd(XCN_OFFS, {24'h0, 3'b010, k[1:0], seed[0] & ~seed[1], seed[0], seed[1]},
                RESP_OKAY);
            seed = xs(seed);
        end
        // Byte lane off: write answered but control left as it was
        wstrb <= 4'h0;
        axi_wr(XCN_OFFS, 8'h00, RESP_OKAY);
        wstrb <= 4'h1;
        repeat (2) @(posedge clk_i);
        chk_pin(8'h8C);
        axi_wr(XCN_OFFS, 8'h00, RESP_OKAY);
        tokens(1'b0);
        chk_bus(q_b.size() + q_r.size() + q_t.size(), 32'h0);
        report_and_stop();
    end
endmodule
